// ===== verilog/dpsc_ctrl.sv
// host-side controller driving one port of an asynchronous dual-port ram
// Function
// - keep read/write high during reads
// - semaphore reads always use select-driven cycles
// - address valid before select falls
// - ram: port low token high; token: reverse
// - read/write high while address changes
// - host never drives data while device drives
// - port select high for semaphore write/read
`timescale 1ns/1ps
`include "dpsc_regs.svh"
module dpsc_ctrl
	import dpsc_pkg::*;
#(
	parameter int ACCESS_CYC = `DPSC_CYC_ACCESS,
	parameter int WPULSE_CYC = `DPSC_CYC_WPULSE,
	parameter int SETUP_CYC  = `DPSC_CYC_SETUP
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        req,
	input  wire logic        req_write,
	input  wire logic        req_token,
	input  wire logic [16:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             busy,
	output logic             done,
	output logic [7:0]       rdata,
	output logic             collided,
	output logic             port_sel_n,
	output logic             token_select_n,
	output logic             rw_n,
	output logic             oe_n,
	output logic [16:0]      addr,
	output logic [7:0]       dq_out,
	output logic             dq_oe_n,
	input  wire logic [7:0]  dq_in,
	input  wire logic        collision_n
);
	logic       rst_meta;
	logic       rst_sync;
	logic [7:0] dq_meta;
	logic [7:0] dq_sync;
	logic       col_meta;
	logic       col_sync;
	logic       req_token_q;
	dpsc_regs_t r;
	dpsc_regs_t next_r;
	// idle strobes high and data pins released while in reset
	localparam dpsc_regs_t RESET_R = '{
		state:          DPSC_IDLE,
		cnt:            4'h0,
		is_wr:          1'b0,
		done:           1'b0,
		busy:           1'b0,
		port_sel_n:     1'b1,
		token_select_n: 1'b1,
		rw_n:           1'b1,
		oe_n:           1'b1,
		addr:           17'h00000,
		dq_out:         8'h00,
		dq_oe_n:        1'b1,
		rdata:          8'h00,
		collided:       1'b0
	};

	// reset is released through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// pins from the device are asynchronous to ref_clk
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			dq_meta  <= 8'h00;
			dq_sync  <= 8'h00;
			col_meta <= 1'b1;
			col_sync <= 1'b1;
		end else begin
			dq_meta  <= dq_in;
			dq_sync  <= dq_meta;
			col_meta <= collision_n;
			col_sync <= col_meta;
		end
	end

	always_comb begin
		next_r          = r;
		next_r.done     = 1'b0;
		next_r.cnt      = (r.cnt == 4'h0) ? 4'h0 : r.cnt - 4'h1;
		unique case (r.state)
			DPSC_IDLE: begin
				next_r.busy = 1'b0;
				if (req) begin
					// address moves only with read/write high
					next_r.rw_n           = 1'b1;
					next_r.addr           = req_addr;
					next_r.dq_out         = req_wdata;
					next_r.is_wr          = req_write;
					next_r.busy           = 1'b1;
					next_r.collided       = 1'b0;
					// both selects stay high until the address has settled
					next_r.port_sel_n     = 1'b1;
					next_r.token_select_n = 1'b1;
					next_r.oe_n           = 1'b1;
					next_r.dq_oe_n        = 1'b1;
					next_r.cnt            = SETUP_CYC[3:0];
					next_r.state          = DPSC_SETUP;
				end
			end
			DPSC_SETUP: begin
				// address held a setup time before select falls
				if (r.cnt == 4'h0) begin
					// ram or token space by select pair
					next_r.port_sel_n     = req_token_q;
					next_r.token_select_n = ~req_token_q;
					if (r.is_wr) begin
						// read/write low with select keeps device quiet
						next_r.rw_n    = 1'b0;
						// drive data only while device is off
						next_r.dq_oe_n = 1'b0;
						next_r.cnt     = WPULSE_CYC[3:0];
						next_r.state   = DPSC_WR_PULSE;
					end else begin
						next_r.rw_n  = 1'b1;
						next_r.oe_n  = 1'b0;
						// two more cycles for the data synchroniser, so the sample lands after access time
						next_r.cnt   = ACCESS_CYC[3:0] + 4'h2;
						next_r.state = DPSC_RD_WAIT;
					end
				end
			end
			DPSC_RD_WAIT: begin
				// every read is select-driven, semaphores included
				if (r.cnt == 4'h0) begin
					next_r.rdata      = dq_sync;
					next_r.collided   = ~col_sync;
					next_r.oe_n       = 1'b1;
					next_r.port_sel_n = 1'b1;
					next_r.token_select_n = 1'b1;
					next_r.state      = DPSC_DONE;
				end
			end
			DPSC_WR_PULSE: begin
				// a low collision flag is recorded
				if (!col_sync) begin
					next_r.collided = 1'b1;
				end
				// stretching the pulse keeps our data on the pins until release
				// loser waits while flag is held low
				if (r.cnt == 4'h0 && col_sync) begin
					// select rises first, ending the write
					next_r.port_sel_n     = 1'b1;
					next_r.token_select_n = 1'b1;
					next_r.state          = DPSC_WR_END;
				end
			end
			DPSC_WR_END: begin
				// read/write returns high after the write window
				// port select stays high across token cycles
				next_r.rw_n    = 1'b1;
				next_r.dq_oe_n = 1'b1;
				next_r.cnt     = 4'(`DPSC_CYC_SEM_WR_RD);
				next_r.state   = DPSC_DONE;
			end
			DPSC_DONE: begin
				// a semaphore readback shows which port won
				if (r.cnt == 4'h0) begin
					next_r.done  = 1'b1;
					next_r.busy  = 1'b0;
					next_r.state = DPSC_IDLE;
				end
			end
			default: begin
				next_r.state = DPSC_IDLE;
			end
		endcase
	end

	// token choice captured at request acceptance
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			req_token_q <= 1'b0;
		end else if (r.state == DPSC_IDLE && req) begin
			req_token_q <= req_token;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			r <= RESET_R;
		end else begin
			r <= next_r;
		end
	end

	assign busy           = r.busy;
	assign done           = r.done;
	assign rdata          = r.rdata;
	assign collided       = r.collided;
	assign port_sel_n     = r.port_sel_n;
	assign token_select_n = r.token_select_n;
	assign rw_n           = r.rw_n;
	assign oe_n           = r.oe_n;
	assign addr           = r.addr;
	assign dq_out         = r.dq_out;
	assign dq_oe_n        = r.dq_oe_n;
endmodule

// ===== verilog/dpsc_regs.svh
// timing constants and widths for the dual-port memory port controller
`ifndef DPSC_REGS_SVH
`define DPSC_REGS_SVH
`define DPSC_CLK_PERIOD_PS   5000
`define DPSC_ADDR_WIDTH      17
`define DPSC_DATA_WIDTH      8
// access and pulse times in ps, as printed for the slowest grade
`define DPSC_T_ACCESS_PS     25000
`define DPSC_T_WPULSE_PS     22000
`define DPSC_T_SETUP_PS      5000
`define DPSC_T_SEM_WR_RD_PS  5000
// least times round up to whole cycles
`define DPSC_CYC(ps) ((((ps) + `DPSC_CLK_PERIOD_PS - 1) / `DPSC_CLK_PERIOD_PS) < 1 ? 1 : \
	(((ps) + `DPSC_CLK_PERIOD_PS - 1) / `DPSC_CLK_PERIOD_PS))
`define DPSC_CYC_ACCESS      `DPSC_CYC(`DPSC_T_ACCESS_PS)
`define DPSC_CYC_WPULSE      `DPSC_CYC(`DPSC_T_WPULSE_PS)
`define DPSC_CYC_SETUP       `DPSC_CYC(`DPSC_T_SETUP_PS)
`define DPSC_CYC_SEM_WR_RD   `DPSC_CYC(`DPSC_T_SEM_WR_RD_PS)
`define DPSC_CNT_WIDTH       4
`endif

// ===== verilog/dpsc_pkg.sv
// types for the dual-port memory port controller
package dpsc_pkg;
	typedef enum logic [2:0] {
		DPSC_IDLE,
		DPSC_SETUP,
		DPSC_RD_WAIT,
		DPSC_WR_PULSE,
		DPSC_WR_END,
		DPSC_DONE
	} dpsc_state_t;

	typedef struct packed {
		dpsc_state_t state;
		logic [3:0]  cnt;
		logic        is_wr;
		logic        done;
		logic        busy;
		logic        port_sel_n;
		logic        token_select_n;
		logic        rw_n;
		logic        oe_n;
		logic [16:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe_n;
		logic [7:0]  rdata;
		logic        collided;
	} dpsc_regs_t;
endpackage

// ===== verif/dpsc_ctrl_chk.sv
// strobe-order assertions on the port controller
`timescale 1ns/1ps
module dpsc_ctrl_chk (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        port_sel_n,
	input wire logic        token_select_n,
	input wire logic        rw_n,
	input wire logic        oe_n,
	input wire logic [16:0] addr,
	input wire logic        dq_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_read_rw_high: assert property (!oe_n |-> rw_n) else $error("rw low in read");
	chk_token_addr_held: assert property (!token_select_n |-> $stable(addr))
		else $error("token addr moved");
	chk_addr_before_sel: assert property ($fell(port_sel_n && token_select_n) |-> $stable(addr))
		else $error("addr late");
	chk_one_space: assert property (port_sel_n || token_select_n) else $error("both selects low");
	chk_addr_move_rw: assert property (!$stable(addr) |-> rw_n && $past(rw_n))
		else $error("addr moved");
	chk_no_contention: assert property (!oe_n |-> dq_oe_n) else $error("bus contention");
	chk_drive_in_write: assert property (!dq_oe_n |-> !rw_n) else $error("data driven outside write");
	chk_token_port_high: assert property (!token_select_n || !$past(token_select_n) |-> port_sel_n)
		else $error("port select low");
endmodule
bind dpsc_ctrl dpsc_ctrl_chk u_chk (.ref_clk, .rst_b, .port_sel_n, .token_select_n, .rw_n, .oe_n, .addr, .dq_oe_n);

// ===== verif/dpsc_dev.sv
// behavioural model of one port of the dual-port device
`timescale 1ns/1ps
module dpsc_dev (
	input wire logic        port_sel_n,
	input wire logic        token_select_n,
	input wire logic        rw_n,
	input wire logic        oe_n,
	input wire logic [16:0] addr,
	input wire logic [7:0]  dq_out,
	input wire logic        dq_oe_n,
	input wire logic        other_on,
	input wire logic [16:0] other_addr,
	input wire logic [31:0] dly,
	output logic [7:0]      dq_in,
	output logic            collision_n
);
	logic [7:0] mem [int];
	logic [7:0] tok = 8'hFF, last = 8'h00, rd = 8'h00;
	logic       is_tok, rd_ok = 1'b0;
	wire        sel = !port_sel_n || !token_select_n;
	wire        wr = !rw_n && sel;
	wire        drv = !oe_n && rw_n && sel;
	// store at first strobe rise; held token not granted
	always @(posedge wr) is_tok = !token_select_n;
	always @(negedge wr) begin
		if (is_tok === 1'b1 && !other_on) tok[addr[2:0]] = dq_out[0];
		else if (is_tok === 1'b0) mem[addr] = dq_out;
	end
	// drives only with read/write high; a slow answer shows garbage first
	always @(drv) begin
		rd_ok = 1'b0;
		if (drv) begin
			rd = !token_select_n ? {7'h00, tok[addr[2:0]]} : (mem.exists(addr) ? mem[addr] : 8'h00);
			rd_ok <= #(dly) 1'b1;
		end else last = rd;
	end
	// no pull on the line, so released pins show the inverse
	always @* dq_in = !dq_oe_n ? dq_out : drv ? (rd_ok ? rd : ~rd) : ~last;
	// other port won: flag only here, until it lets go
	assign collision_n = !(other_on && !port_sel_n && addr == other_addr);
endmodule

// ===== verif/test_dual_port_ram_port_access.sv
// self-checking bench for the port controller with a device model
`timescale 1ns/1ps
module test_dual_port_ram_port_access;
	logic        ref_clk = 0, rst_b = 0, req = 0, req_write = 0, req_token = 0, other_on = 0;
	logic [16:0] req_addr = 0, other_addr = 17'h00055;
	logic [7:0]  req_wdata = 0, ref_mem [int];
	wire logic   busy, done, collided, port_sel_n, token_select_n, rw_n, oe_n, dq_oe_n, collision_n;
	wire logic [7:0]  rdata, dq_out, dq_in;
	wire logic [16:0] addr;
	int          fails = 0, checked = 0, seed = 16814, dly = 5, cyc, i, k;
	dpsc_ctrl dut (.ref_clk, .rst_b, .req, .req_write, .req_token, .req_addr, .req_wdata, .busy, .done, .rdata,
		.collided, .port_sel_n, .token_select_n, .rw_n, .oe_n, .addr, .dq_out, .dq_oe_n, .dq_in, .collision_n);
	dpsc_dev u_dev (.port_sel_n, .token_select_n, .rw_n, .oe_n, .addr, .dq_out, .dq_oe_n, .other_on,
		.other_addr, .dly, .dq_in, .collision_n);
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic run(input logic w, input logic t, input logic [16:0] a, input logic [7:0] d);
		req <= 1;
		req_write <= w;
		req_token <= t;
		req_addr <= a;
		req_wdata <= d;
		for (cyc = 0; cyc < 99 && busy !== 1'b1; cyc++) @(negedge ref_clk);
		req <= 0;
		if (cyc == 99) begin
			fails++;
			complete_run;
		end
		for (cyc = 0; cyc < 99 && done !== 1'b1; cyc++) @(negedge ref_clk);
		if (cyc == 99) begin
			fails++;
			complete_run;
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [16:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
	endfunction
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_b = 1;
		repeat (3) @(negedge ref_clk);
		// random writes read back, end addresses first, fast and slow answers
		for (i = 0; i < 40; i++) begin
			k = $random(seed);
			if (i < 2) k[16:0] = {17{i[0]}};
			dly = 5 + k[3:0];
			run(1, 0, k[16:0], k[31:24]);
			ref_mem[k[16:0]] = k[31:24];
			run(0, 0, k[16:0], 8'h00);
			chk(rdata, exp_rd(k[16:0]));
			chk({7'h00, collided}, 8'h00);
		end
		// other port holds the location; write waits for its release
		other_on = 1;
		fork
			run(1, 0, 17'h00055, 8'hA5);
			begin repeat (20) @(negedge ref_clk); other_on = 0; end
		join
		chk({7'h00, collided}, 8'h01);
		chk({7'h00, cyc > 15}, 8'h01);
		ref_mem[17'h00055] = 8'hA5;
		run(0, 0, 17'h00055, 8'h00);
		chk(rdata, exp_rd(17'h00055));
		// tokens granted when free, refused while the other side holds them
		for (i = 0; i < 4; i++) begin
			other_on = i[1];
			run(1, 1, 17'(i), 8'h00);
			run(0, 1, 17'(i), 8'h00);
			chk(rdata, {7'h00, i[1]});
			run(1, 1, 17'(i), 8'h01);
		end
		complete_run;
	end
endmodule
